// file: rtl/carry_lookahead_adder_4bit.sv
`timescale 1ns/1ps
// Overview of operation
// - Cell takes two bits, carry; gives sum, carry
// - Sum odd parity; carry on two or more
// - Ripple chain links each carry to next
// - Bit zero sum is A0^B0^cin
// - Bit zero carry is majority with cin
// - Look-ahead carries all formed in parallel
// - Carry-out ORs generate terms with propagates
// - Four-bit carry-out from bits three..zero, cin
// - Pre-decode held A, input B into ORs
// - Product term selects any of sixteen ANDs
// - Sum bits combine groups through XOR
// - Top sum uses look-ahead carry into bit3
module carry_lookahead_adder_4bit (
  // Clock and reset for held operand
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // Held operand load
  input  wire logic                      a_load,
  input  wire logic [cla_pkg::WIDTH-1:0] a_in,
  // Live operand and carry
  input  wire logic [cla_pkg::WIDTH-1:0] b_in,
  input  wire logic                      carry_in,
  // Product term selection per bit
  input  wire logic [cla_pkg::DEC_W-1:0] term_sel [cla_pkg::WIDTH],
  // Look-ahead results
  output logic      [cla_pkg::WIDTH-1:0] sum,
  output logic                           carry_out,
  // Ripple results
  output logic      [cla_pkg::WIDTH-1:0] ripple_sum,
  output logic                           ripple_carry_out,
  // Selected product terms
  output logic      [cla_pkg::WIDTH-1:0] term_out,
  // Held operand view
  output logic      [cla_pkg::WIDTH-1:0] a_held
);
  // ****************************************
  // Declarations
  // ****************************************
  // Held operand
  logic [cla_pkg::WIDTH-1:0] a_q;
  logic [cla_pkg::WIDTH-1:0] a_d;

  // Bit-pair lanes and pair terms
  logic [cla_pkg::DEC_W-1:0] dec [cla_pkg::WIDTH];
  logic [cla_pkg::WIDTH-1:0] gen;
  logic [cla_pkg::WIDTH-1:0] prop;
  logic [cla_pkg::WIDTH-1:0] half;

  // Look-ahead carry network
  logic [cla_pkg::WIDTH-1:0] chain [cla_pkg::WIDTH];
  logic [cla_pkg::WIDTH-1:0] pterm [cla_pkg::WIDTH];
  logic [cla_pkg::WIDTH-1:0] cla_c;
  logic [cla_pkg::WIDTH:0]   co_term;

  // Ripple chain
  logic [cla_pkg::WIDTH:0]   rip_c;

  // ****************************************
  // Term select function
  // ****************************************
  // Each select bit enables one pre-decoded OR into the AND
  function automatic logic pick_term(input logic [cla_pkg::DEC_W-1:0] d,
                                     input logic [cla_pkg::DEC_W-1:0] s);
    logic r;
    r = 1'b1;
    for (int k = 0; k < int'(cla_pkg::DEC_W); k++) begin
      if (s[k]) begin
        r = r & d[k];
      end
    end
    return r;
  endfunction : pick_term

  // ****************************************
  // Bit-pair decode function
  // ****************************************
  // Four OR lanes of one operand bit pair
  function automatic logic [cla_pkg::DEC_W-1:0] pair_decode(input logic a,
                                                           input logic b);
    logic [cla_pkg::DEC_W-1:0] d;
    d                        = '0;
    d[cla_pkg::DEC_A_OR_B]   = a | b;
    d[cla_pkg::DEC_A_OR_NB]  = a | ~b;
    d[cla_pkg::DEC_NA_OR_B]  = ~a | b;
    d[cla_pkg::DEC_NA_OR_NB] = ~a | ~b;
    return d;
  endfunction : pair_decode

  // ****************************************
  // Held operand register
  // ****************************************
  // Loads on a_load, reset clears
  assign a_d = a_load ? a_in : a_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      a_q <= '0;
    end else begin
      a_q <= a_d;
    end
  end
  assign a_held = a_q;

  // ****************************************
  // Bit-pair decode and product terms
  // ****************************************
  genvar i;
  genvar j;
  generate
    for (i = 0; i < int'(cla_pkg::WIDTH); i++) begin : g_bit
      // Four OR lanes feed the product-term array
      assign dec[i]      = pair_decode(a_q[i], b_in[i]);
      assign term_out[i] = pick_term(dec[i], term_sel[i]);
    end
  endgenerate

  // ****************************************
  // Generate, propagate and half sum
  // ****************************************
  generate
    for (i = 0; i < int'(cla_pkg::WIDTH); i++) begin : g_pair
      // Generate is A*B: /A+B, A+/B, A+B all true
      assign gen[i]  = dec[i][cla_pkg::DEC_A_OR_B]
                     & dec[i][cla_pkg::DEC_A_OR_NB]
                     & dec[i][cla_pkg::DEC_NA_OR_B];
      // Propagate is A+B
      assign prop[i] = dec[i][cla_pkg::DEC_A_OR_B];
      // Half sum is A^B: one of A+/B, /A+B is false
      assign half[i] = ~dec[i][cla_pkg::DEC_A_OR_NB]
                     ^ ~dec[i][cla_pkg::DEC_NA_OR_B];
    end
  endgenerate

  // ****************************************
  // Propagate chains
  // ****************************************
  // Row n, column k: AND of propagates k up to n-1
  // Columns at or above n stay open
  generate
    for (i = 0; i < int'(cla_pkg::WIDTH); i++) begin : g_chain_row
      for (j = 0; j < int'(cla_pkg::WIDTH); j++) begin : g_chain_col
        if (j >= i) begin : g_open
          assign chain[i][j] = 1'b1;
        end else begin : g_span
          assign chain[i][j] = &prop[i-1:j];
        end
      end
    end
  endgenerate

  // ****************************************
  // Product-term array
  // ****************************************
  // Row n holds the terms of the carry into bit n
  // Columns above n tie low
  generate
    for (i = 0; i < int'(cla_pkg::WIDTH); i++) begin : g_pt_row
      for (j = 0; j < int'(cla_pkg::WIDTH); j++) begin : g_pt_col
        if (j < i) begin : g_gen_term
          assign pterm[i][j] = gen[j] & chain[i][j+1];
        end else if (j == i) begin : g_cin_term
          assign pterm[i][j] = carry_in & chain[i][0];
        end else begin : g_idle
          assign pterm[i][j] = 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Carry OR plane
  // ****************************************
  // One OR gate per carry row, all rows in parallel
  generate
    for (i = 0; i < int'(cla_pkg::WIDTH); i++) begin : g_carry
      assign cla_c[i] = |pterm[i];
    end
  endgenerate

  // ****************************************
  // Four-bit carry-out
  // ****************************************
  // Top generate first, carry input last
  assign co_term[0] = gen[3];
  assign co_term[1] = prop[3] & gen[2];
  assign co_term[2] = prop[3] & prop[2]
                    & gen[1];
  assign co_term[3] = prop[3] & prop[2] & prop[1]
                    & gen[0];
  assign co_term[4] = prop[3] & prop[2] & prop[1]
                    & prop[0] & carry_in;
  assign carry_out  = |co_term;

  // ****************************************
  // Sum bits
  // ****************************************
  // Half sum XORed with the carry group, never ORed
  generate
    for (i = 0; i < int'(cla_pkg::WIDTH); i++) begin : g_sum
      assign sum[i] = half[i] ^ cla_c[i];
    end
  endgenerate

  // ****************************************
  // Ripple chain
  // ****************************************
  // Kept beside the look-ahead form as a second result
  assign rip_c[0] = carry_in;
  generate
    for (i = 0; i < int'(cla_pkg::WIDTH); i++) begin : g_rip
      full_adder_cell u_cell (
        .a    (a_q[i]),
        .b    (b_in[i]),
        .cin  (rip_c[i]),
        .sum  (ripple_sum[i]),
        .cout (rip_c[i+1])
      );
    end
  endgenerate
  assign ripple_carry_out = rip_c[cla_pkg::WIDTH];
endmodule : carry_lookahead_adder_4bit

// file: rtl/cla_pkg.sv
package cla_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned WIDTH = 4;
  localparam int unsigned DEC_W = 4;
  // ****************************************
  // Pre-decode lane positions
  // ****************************************
  localparam int unsigned DEC_A_OR_B   = 0;
  localparam int unsigned DEC_A_OR_NB  = 1;
  localparam int unsigned DEC_NA_OR_B  = 2;
  localparam int unsigned DEC_NA_OR_NB = 3;
  // ****************************************
  // Product term select codes
  // ****************************************
  localparam logic [3:0] SEL_ONE  = 4'h0;
  localparam logic [3:0] SEL_AND  = 4'h7;
  localparam logic [3:0] SEL_XOR  = 4'h9;
  localparam logic [3:0] SEL_XNOR = 4'h6;
  localparam logic [3:0] SEL_OR   = 4'h1;
  localparam logic [3:0] SEL_NOR  = 4'hE;
endpackage : cla_pkg

// file: rtl/full_adder_cell.sv
`timescale 1ns/1ps
module full_adder_cell (
  // Operand bits
  input  wire logic a,
  input  wire logic b,
  input  wire logic cin,
  // Results
  output logic      sum,
  output logic      cout
);
  // ****************************************
  // Bit cell
  // ****************************************
  assign sum  = a ^ b ^ cin;
  assign cout = (a & b) | ((a | b) & cin);
endmodule : full_adder_cell

// file: test/cla_chk.sv
`timescale 1ns/1ps
module cla_chk (
  input wire logic       clk_sys, nrst, a_load, carry_in, carry_out, ripple_carry_out,
  input wire logic [3:0] a_in, b_in, a_held, sum, ripple_sum, term_out,
  input wire logic [3:0] term_sel [4]
);
  wire [4:0] f = a_held + b_in + carry_in;
  wire [4:0] t = a_held[2:0] + b_in[2:0] + carry_in;
  wire       c1 = a_held[0] & b_in[0] | (a_held[0] | b_in[0]) & carry_in;
  function automatic logic [3:0] pick(input logic [3:0] a, b, input logic [3:0] s [4]);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) r[i] = &({~a[i] | ~b[i], ~a[i] | b[i], a[i] | ~b[i], a[i] | b[i]} | ~s[i]);
    return r;
  endfunction : pick
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_full_sum: assert property ({carry_out, sum} == f)
    else $error("bad sum");
  a_ripple_same: assert property ({ripple_carry_out, ripple_sum} == f)
    else $error("bad ripple");
  a_bit0_sum: assert property (sum[0] == (a_held[0] ^ b_in[0] ^ carry_in))
    else $error("bad bit0");
  a_bit0_carry: assert property (sum[1] == (a_held[1] ^ b_in[1] ^ c1))
    else $error("bad carry0");
  a_top_sum: assert property (sum[3] == (a_held[3] ^ b_in[3] ^ t[3]))
    else $error("bad top");
  a_term_pick: assert property (term_out == pick(a_held, b_in, term_sel))
    else $error("bad term");
  a_load_take: assert property (a_load |=> a_held == $past(a_in))
    else $error("bad load");
  a_held_keep: assert property (!a_load |=> $stable(a_held))
    else $error("bad hold");
  c_carry: cover property (carry_out);
  c_load: cover property (a_load ##1 a_load);
  c_wrap: cover property (carry_out && sum == 4'h0);
endmodule : cla_chk
bind carry_lookahead_adder_4bit cla_chk chk_u (
  .clk_sys          (clk_sys),
  .nrst             (nrst),
  .a_load           (a_load),
  .carry_in         (carry_in),
  .carry_out        (carry_out),
  .ripple_carry_out (ripple_carry_out),
  .a_in             (a_in),
  .b_in             (b_in),
  .a_held           (a_held),
  .sum              (sum),
  .ripple_sum       (ripple_sum),
  .term_out         (term_out),
  .term_sel         (term_sel)
);

// file: test/operand_feed.sv
`timescale 1ns/1ps
module operand_feed (
  input wire logic       clk_sys, c_req,
  input wire logic [3:0] b_req,
  output logic           carry_in,
  output logic [3:0]     b_in
);
  always_ff @(posedge clk_sys) begin
    b_in     <= b_req;
    carry_in <= c_req;
  end
endmodule : operand_feed

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clk_sys = 0, nrst = 0, a_load = 0, c_req = 0, carry_in, carry_out, rco;
  logic [3:0] a_in = 0, b_req = 0, b_in, sum, rs, t_out, a_held;
  logic [3:0] term_sel [4] = '{default: cla_pkg::SEL_XOR};
  logic [19:0] rows [7] = '{20'h5_3109, 20'hF_0110, 20'hF_F11F, 20'h0_0000, 20'h8_8010, 20'hA_500F, 20'h7_1008};
  int bad_count = 0, check_count = 0;
  always #10 clk_sys = ~clk_sys;
  carry_lookahead_adder_4bit dut_u (.clk_sys(clk_sys), .nrst(nrst), .a_load(a_load), .a_in(a_in),
    .b_in(b_in), .carry_in(carry_in), .term_sel(term_sel), .sum(sum), .carry_out(carry_out),
    .ripple_sum(rs), .ripple_carry_out(rco), .term_out(t_out), .a_held(a_held));
  operand_feed feed_u (.clk_sys(clk_sys), .c_req(c_req), .b_req(b_req), .carry_in(carry_in), .b_in(b_in));
  task automatic chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [3:0] want_term(input logic [3:0] a, b, s);
    logic [3:0] r;
    for (int k = 0; k < 4; k++) begin
      r[k] = (!s[0] || a[k] || b[k]) && (!s[1] || a[k] || !b[k])
          && (!s[2] || !a[k] || b[k]) && (!s[3] || !a[k] || !b[k]);
    end
    return r;
  endfunction : want_term
  task automatic op(input logic [3:0] a, b, input logic c);
    @(negedge clk_sys);
    a_in = a;
    a_load = 1;
    b_req = b;
    c_req = c;
    @(negedge clk_sys);
    a_load = 0;
  endtask : op
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #5000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1;
    foreach (rows[i]) begin
      op(rows[i][19:16], rows[i][15:12], rows[i][8]);
      chk({3'b0, carry_out, sum}, rows[i][7:0]);
      chk({3'b0, rco, rs}, rows[i][7:0]);
      chk({4'b0, t_out}, {4'b0, rows[i][19:16] ^ rows[i][15:12]});
    end
    $display("rows done");
    for (int s = 0; s < 16; s++) begin
      @(negedge clk_sys);
      term_sel = '{default: 4'(s)};
      #1;
      chk({4'b0, t_out}, {4'b0, want_term(rows[6][19:16], rows[6][15:12], 4'(s))});
    end
    $display("select sweep done");
    @(negedge clk_sys);
    a_in = 4'h3;
    a_load = 1;
    @(negedge clk_sys);
    chk({4'b0, a_held}, 8'h03);
    a_in = 4'hC;
    @(negedge clk_sys);
    chk({4'b0, a_held}, 8'h0C);
    a_load = 0;
    a_in = 4'h5;
    @(negedge clk_sys);
    chk({4'b0, a_held}, 8'h0C);
    chk({3'b0, carry_out, sum}, 8'h0D);
    chk({3'b0, rco, rs}, 8'h0D);
    $display("load test done");
    @(negedge clk_sys);
    nrst = 0;
    @(negedge clk_sys);
    nrst = 1;
    chk({4'b0, a_held}, 8'h00);
    chk({3'b0, carry_out, sum}, 8'h01);
    $display("reset done");
    complete_run();
  end
endmodule : tb_top
